// ### inc/pmbsa_consts.svh
// Purpose: constants for the power-management serial slave
// Assumes: pclk at 200 MHz
// Notes:   offsets are byte addresses on the APB register bus
`ifndef PMBSA_CONSTS_SVH
`define PMBSA_CONSTS_SVH
`define PMBSA_CLK_KHZ        200000
`define PMBSA_STRETCH_MAX_MS 35
`define PMBSA_PREP_CYC       24'h000004
`define PMBSA_ARA_ADDR       7'h0c
`define PMBSA_CMD_CLEAR      8'h03
`define PMBSA_CMD_STORE      8'h11
`define PMBSA_CMD_VOUT_MODE  8'h20
`define PMBSA_CMD_VOUT       8'h21
`define PMBSA_CMD_VIN_ON     8'h35
`define PMBSA_CMD_STATUS     8'h78
`define PMBSA_CMD_ALERT_CFG  8'hd5
`define PMBSA_VOUT_MODE_VAL  8'h14
`define PMBSA_VIN_EXP        5'h1d
`define PMBSA_ARA_MODE_BIT   4
`define PMBSA_RST_VOUT       16'hc000
`define PMBSA_RST_VIN_ON     16'he910
`define PMBSA_RST_ALERT_CFG  8'h00
`define PMBSA_RST_CTRL       1'b1
`define PMBSA_STRAP_T1       8'h0d
`define PMBSA_STRAP_T2       8'h13
`define PMBSA_STRAP_T3       8'h1e
`define PMBSA_STRAP_T4       8'h2d
`define PMBSA_STRAP_T5       8'h46
`define PMBSA_STRAP_T6       8'h6b
`define PMBSA_STRAP_T7       8'ha5
`define PMBSA_OFF_CTRL       12'h000
`define PMBSA_OFF_STATUS     12'h004
`define PMBSA_OFF_VOUT       12'h008
`define PMBSA_OFF_VOUT_NV    12'h00c
`define PMBSA_OFF_VIN_ON     12'h010
`define PMBSA_OFF_VIN_ON_NV  12'h014
`define PMBSA_OFF_ALERT_CFG  12'h018
`endif

// ### inc/pmbsa_pkg.sv
// Purpose: types for the power-management serial slave
// Assumes: nothing
// Notes:   one-hot byte engine states
package pmbsa_pkg;
  typedef enum logic [6:0] {
    ST_IDLE = 7'h01,
    ST_ADDR = 7'h02,
    ST_ACKA = 7'h04,
    ST_RX   = 7'h08,
    ST_ACKR = 7'h10,
    ST_TX   = 7'h20,
    ST_ACKT = 7'h40
  } pmbsa_state_t;
endpackage

// ### hdl/pmbsa_slave.sv
// Purpose: two-wire power-management slave with alert and strapped address
// Assumes: bus pins and straps arrive asynchronously and are synchronised here
// Notes:   non-volatile copies are modelled as flops reset to factory values
//
// What this block does
// RULE1 - works at 100 kHz and 400 kHz
// RULE2 - clock stretch always ends before 35 ms
// RULE3 - check master's error-check byte when present
// RULE4 - append error-check byte to every response
// RULE5 - accept writes without error-check byte
// RULE6 - linear format, fixed exponent, exponent writes ignored
// RULE7 - direct number format not supported
// RULE8 - writes change working setting only
// RULE9 - store-all copies settings to non-volatile memory
// RULE10 - drive alert low while any condition active
// RULE11 - answer exactly one bus address at once
// RULE12 - default mode keeps strapped address during alert
// RULE13 - clear-faults releases the alert
// RULE14 - config bit 4 selects alert-response mode
// RULE15 - response mode drops strapped address during alert
// RULE16 - master reads response address to retire alert
// RULE17 - after retire, strapped address answers again
// RULE18 - no arbitration on shared alert-response reads
// RULE19 - address is high digit then low digit
// RULE20 - strap resistance decodes to one octal digit
// RULE21 - integrator avoids reserved addresses
// RULE22 - straps latched once after reset
//
// Added by the designer: the register addresses and the APB register port.
`timescale 1ns/10ps
`include "pmbsa_consts.svh"
module pmbsa_slave
  import pmbsa_pkg::*;
#(
  parameter int STRETCH_MAX_CYC = `PMBSA_STRETCH_MAX_MS * `PMBSA_CLK_KHZ
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        scl_i,
  output logic             scl_o,
  output logic             scl_oe,
  input  wire logic        sda_i,
  output logic             sda_o,
  output logic             sda_oe,
  output logic             alert_o,
  output logic             alert_oe,
  input  wire logic [3:0]  fault_in,
  input  wire logic [7:0]  address_low_digit_strap,
  input  wire logic [7:0]  address_high_digit_strap
);

  function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] d);
    logic [7:0] r;
    r = c ^ d;
    for (int i = 0; i < 8; i++) begin
      r = r[7] ? ({r[6:0], 1'b0} ^ 8'h07) : {r[6:0], 1'b0};
    end
    return r;
  endfunction

  // midpoints between neighbouring resistor values, in kilohm units
  function automatic logic [2:0] strap_digit(input logic [7:0] k);
    logic [2:0] d;
    d = 3'h0;
    if (k >= `PMBSA_STRAP_T1) d = 3'h1;
    if (k >= `PMBSA_STRAP_T2) d = 3'h2;
    if (k >= `PMBSA_STRAP_T3) d = 3'h3;
    if (k >= `PMBSA_STRAP_T4) d = 3'h4;
    if (k >= `PMBSA_STRAP_T5) d = 3'h5;
    if (k >= `PMBSA_STRAP_T6) d = 3'h6;
    if (k >= `PMBSA_STRAP_T7) d = 3'h7;
    return d;
  endfunction

  logic [2:0]   scl_s, sda_s;
  logic [3:0]   fault_s1, fault_s2;
  logic [7:0]   lo_s1, lo_s2, hi_s1, hi_s2;
  logic [1:0]   strap_wait_r;
  logic         strap_ok_r;
  logic [5:0]   strap_addr_r;
  pmbsa_state_t state_r;
  logic [2:0]   bitcnt_r;
  logic [7:0]   shreg_r;
  logic [7:0]   buf_r [4];
  logic [2:0]   nb_r;
  logic [7:0]   crc_r, crc_prev_r;
  logic         rd_r, ara_hit_r, in_txn_r, ack_drv_r, exec_r, stretch_req_r, ara_retire_r;
  logic [1:0]   tx_idx_r;
  logic [7:0]   tx_sh_r;
  logic         sda_oe_r, scl_oe_r, alert_oe_r, od_low_r;
  logic [23:0]  stretch_cnt_r;
  logic         ctrl_en_r;
  logic [15:0]  vout_w_r, vout_nv_r, vin_on_w_r, vin_on_nv_r;
  logic [7:0]   alert_cfg_w_r, alert_cfg_nv_r;
  logic [4:0]   status_r;
  logic         retired_r;
  logic [31:0]  prdata_r;
  logic         pready_r, pslverr_r;

  // edges compare the second and third stages; the first stage feeds nothing else
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scl_s    <= 3'h7;
      sda_s    <= 3'h7;
      fault_s1 <= 4'h0;
      fault_s2 <= 4'h0;
    end else begin
      scl_s    <= {scl_s[1:0], scl_i};
      sda_s    <= {sda_s[1:0], sda_i};
      fault_s1 <= fault_in;
      fault_s2 <= fault_s1;
    end
  end

  // 200 MHz oversampling leaves ample margin at 400 kHz
  logic scl_rise, scl_fall, start_det, stop_det;
  assign scl_rise  = scl_s[1] & ~scl_s[2]; // RULE1
  assign scl_fall  = ~scl_s[1] & scl_s[2];
  assign start_det = scl_s[1] & scl_s[2] & sda_s[2] & ~sda_s[1];
  assign stop_det  = scl_s[1] & scl_s[2] & ~sda_s[2] & sda_s[1];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lo_s1        <= 8'h00;
      lo_s2        <= 8'h00;
      hi_s1        <= 8'h00;
      hi_s2        <= 8'h00;
      strap_wait_r <= 2'h0;
      strap_ok_r   <= 1'b0;
      strap_addr_r <= 6'h00;
    end else begin
      lo_s1 <= address_low_digit_strap;
      lo_s2 <= lo_s1;
      hi_s1 <= address_high_digit_strap;
      hi_s2 <= hi_s1;
      if (!strap_ok_r) begin
        strap_wait_r <= strap_wait_r + 2'h1;
        if (strap_wait_r == 2'h3) begin
          strap_ok_r   <= 1'b1; // RULE22
          strap_addr_r <= {strap_digit(hi_s2), strap_digit(lo_s2)}; // RULE19 RULE20
        end
      end
    end
  end

  logic       alert_act, ara_now;
  logic [6:0] active_addr;
  assign alert_act   = (|status_r) & ~retired_r;
  assign ara_now     = alert_cfg_w_r[`PMBSA_ARA_MODE_BIT] & alert_act; // RULE14
  // one address at a time: response address only in response mode with alert
  assign active_addr = ara_now ? `PMBSA_ARA_ADDR : {1'b0, strap_addr_r}; // RULE11 RULE12 RULE15

  logic [1:0]  rlen;
  logic [15:0] rword;
  logic [7:0]  tx_next, tx_crc_nxt;
  always_comb begin
    rlen  = 2'h0;
    rword = 16'h0000;
    if (ara_hit_r) begin
      rlen  = 2'h1;
      rword = {8'h00, 1'b0, strap_addr_r, 1'b0};
    end else begin
      case (buf_r[0])
        `PMBSA_CMD_VOUT_MODE: begin
          rlen  = 2'h1;
          rword = {8'h00, `PMBSA_VOUT_MODE_VAL}; // RULE7
        end
        `PMBSA_CMD_VOUT: begin
          rlen  = 2'h2;
          rword = vout_w_r;
        end
        `PMBSA_CMD_VIN_ON: begin
          rlen  = 2'h2;
          rword = vin_on_w_r;
        end
        `PMBSA_CMD_STATUS: begin
          rlen  = 2'h1;
          rword = {11'h000, status_r};
        end
        `PMBSA_CMD_ALERT_CFG: begin
          rlen  = 2'h1;
          rword = {8'h00, alert_cfg_w_r};
        end
        default: begin
          rlen  = 2'h0;
          rword = 16'h0000;
        end
      endcase
    end
    if (tx_idx_r < rlen) tx_next = tx_idx_r[0] ? rword[15:8] : rword[7:0];
    else if (tx_idx_r == rlen) tx_next = crc_r; // RULE4
    else tx_next = 8'hff;
    tx_crc_nxt = (tx_idx_r < rlen) ? crc8(crc_r, tx_next) : crc_r;
  end

  logic [7:0] rx_byte;
  assign rx_byte = {shreg_r[6:0], sda_s[1]};

  // byte engine; a shared response read is not arbitrated, data is driven blind
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r       <= ST_IDLE;
      bitcnt_r      <= 3'h0;
      shreg_r       <= 8'h00;
      buf_r         <= '{default: 8'h00};
      nb_r          <= 3'h0;
      crc_r         <= 8'h00;
      crc_prev_r    <= 8'h00;
      rd_r          <= 1'b0;
      ara_hit_r     <= 1'b0;
      in_txn_r      <= 1'b0;
      ack_drv_r     <= 1'b0;
      exec_r        <= 1'b0;
      stretch_req_r <= 1'b0;
      ara_retire_r  <= 1'b0;
      tx_idx_r      <= 2'h0;
      tx_sh_r       <= 8'h00;
      sda_oe_r      <= 1'b0;
    end else begin
      exec_r        <= 1'b0;
      stretch_req_r <= 1'b0;
      ara_retire_r  <= 1'b0;
      if (start_det) begin
        state_r  <= ST_ADDR;
        bitcnt_r <= 3'h0;
        sda_oe_r <= 1'b0;
        if (!in_txn_r) begin
          crc_r <= 8'h00;
          nb_r  <= 3'h0;
        end
      end else if (stop_det) begin
        state_r  <= ST_IDLE;
        sda_oe_r <= 1'b0;
        in_txn_r <= 1'b0;
        exec_r   <= in_txn_r & ~rd_r;
      end else begin
        case (state_r)
          ST_IDLE: begin
            sda_oe_r <= 1'b0;
          end
          ST_ADDR: if (scl_rise) begin
            shreg_r  <= rx_byte;
            bitcnt_r <= bitcnt_r + 3'h1;
            if (bitcnt_r == 3'h7) begin
              if (ctrl_en_r && strap_ok_r && shreg_r[6:0] == active_addr) begin // RULE11
                state_r    <= ST_ACKA;
                rd_r       <= sda_s[1];
                ara_hit_r  <= ara_now;
                in_txn_r   <= 1'b1;
                ack_drv_r  <= 1'b0;
                tx_idx_r   <= 2'h0;
                crc_prev_r <= crc_r;
                crc_r      <= crc8(crc_r, rx_byte);
              end else begin
                state_r  <= ST_IDLE;
                in_txn_r <= 1'b0;
              end
            end
          end
          ST_ACKA: if (scl_fall) begin
            if (!ack_drv_r) begin
              sda_oe_r  <= 1'b1;
              ack_drv_r <= 1'b1;
            end else begin
              ack_drv_r <= 1'b0;
              bitcnt_r  <= rd_r ? 3'h1 : 3'h0;
              if (rd_r) begin
                state_r       <= ST_TX;
                sda_oe_r      <= ~tx_next[7];
                tx_sh_r       <= tx_next;
                crc_r         <= tx_crc_nxt;
                tx_idx_r      <= tx_idx_r + 2'h1;
                stretch_req_r <= 1'b1; // RULE2
              end else begin
                state_r  <= ST_RX;
                sda_oe_r <= 1'b0;
              end
            end
          end
          ST_RX: if (scl_rise) begin
            shreg_r  <= rx_byte;
            bitcnt_r <= bitcnt_r + 3'h1;
            if (bitcnt_r == 3'h7) begin
              if (nb_r < 3'h4) buf_r[nb_r[1:0]] <= rx_byte;
              if (nb_r != 3'h7) nb_r <= nb_r + 3'h1;
              crc_prev_r <= crc_r;
              crc_r      <= crc8(crc_r, rx_byte);
              state_r    <= ST_ACKR;
              ack_drv_r  <= 1'b0;
            end
          end
          ST_ACKR: if (scl_fall) begin
            if (!ack_drv_r) begin
              sda_oe_r  <= 1'b1;
              ack_drv_r <= 1'b1;
            end else begin
              sda_oe_r  <= 1'b0;
              ack_drv_r <= 1'b0;
              bitcnt_r  <= 3'h0;
              state_r   <= ST_RX;
            end
          end
          ST_TX: if (scl_fall) begin
            if (bitcnt_r == 3'h0) begin
              sda_oe_r  <= 1'b0;
              ack_drv_r <= 1'b0;
              state_r   <= ST_ACKT;
            end else begin
              sda_oe_r <= ~tx_sh_r[6]; // RULE18
              tx_sh_r  <= {tx_sh_r[6:0], 1'b0};
              bitcnt_r <= bitcnt_r + 3'h1;
            end
          end
          ST_ACKT: begin
            if (scl_rise) begin
              ara_retire_r <= ara_hit_r && tx_idx_r == 2'h1; // RULE16
              if (sda_s[1]) state_r <= ST_IDLE;
              else ack_drv_r <= 1'b1;
            end else if (scl_fall && ack_drv_r) begin
              ack_drv_r <= 1'b0;
              state_r   <= ST_TX;
              sda_oe_r  <= ~tx_next[7];
              tx_sh_r   <= tx_next;
              crc_r     <= tx_crc_nxt;
              bitcnt_r  <= 3'h1;
              if (tx_idx_r != 2'h3) tx_idx_r <= tx_idx_r + 2'h1;
            end
          end
          default: state_r <= ST_IDLE;
        endcase
      end
    end
  end

  // hold the clock while a response is set up; capped well short of the limit
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scl_oe_r      <= 1'b0;
      stretch_cnt_r <= 24'h000000;
    end else if (stretch_req_r) begin
      scl_oe_r      <= 1'b1;
      stretch_cnt_r <= 24'h000000;
    end else if (scl_oe_r) begin
      stretch_cnt_r <= stretch_cnt_r + 24'h000001;
      if (stretch_cnt_r == `PMBSA_PREP_CYC - 24'h000001 ||
          stretch_cnt_r == 24'(STRETCH_MAX_CYC - 1)) begin
        scl_oe_r <= 1'b0; // RULE2
      end
    end
  end

  // command execution at stop
  logic [2:0] explen;
  logic       pec_given, pec_bad, wr_ok, do_clear, do_store, cml_set, new_evt;
  always_comb begin
    case (buf_r[0])
      `PMBSA_CMD_CLEAR, `PMBSA_CMD_STORE:          explen = 3'h1;
      `PMBSA_CMD_ALERT_CFG, `PMBSA_CMD_VOUT_MODE: explen = 3'h2;
      `PMBSA_CMD_VOUT, `PMBSA_CMD_VIN_ON:         explen = 3'h3;
      default:                                     explen = 3'h0;
    endcase
  end
  assign pec_given = nb_r == explen + 3'h1;
  assign pec_bad   = pec_given && buf_r[explen[1:0]] != crc_prev_r; // RULE3
  assign wr_ok     = exec_r && explen != 3'h0 && (nb_r == explen || !pec_bad); // RULE5
  assign do_clear  = wr_ok && buf_r[0] == `PMBSA_CMD_CLEAR;
  assign do_store  = wr_ok && buf_r[0] == `PMBSA_CMD_STORE;
  // bad error-check, unknown command, mode write raise comms fault; a wrong length does not
  assign cml_set   = exec_r && nb_r != 3'h0 &&
                     (!wr_ok || buf_r[0] == `PMBSA_CMD_VOUT_MODE); // RULE7
  assign new_evt   = (|(fault_s2 & ~status_r[3:0])) | (cml_set & ~status_r[4]);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      vout_w_r      <= `PMBSA_RST_VOUT;
      vin_on_w_r    <= `PMBSA_RST_VIN_ON;
      alert_cfg_w_r <= `PMBSA_RST_ALERT_CFG;
    end else if (wr_ok) begin
      case (buf_r[0])
        `PMBSA_CMD_VOUT:      vout_w_r <= {buf_r[2], buf_r[1]}; // RULE8
        `PMBSA_CMD_VIN_ON:    vin_on_w_r <= {`PMBSA_VIN_EXP, 1'b0, buf_r[2][1:0], buf_r[1]}; // RULE6
        `PMBSA_CMD_ALERT_CFG: alert_cfg_w_r <= buf_r[1]; // RULE14
        default: ;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      vout_nv_r      <= `PMBSA_RST_VOUT;
      vin_on_nv_r    <= `PMBSA_RST_VIN_ON;
      alert_cfg_nv_r <= `PMBSA_RST_ALERT_CFG;
    end else if (do_store) begin
      vout_nv_r      <= vout_w_r; // RULE9
      vin_on_nv_r    <= vin_on_w_r;
      alert_cfg_nv_r <= alert_cfg_w_r;
    end
  end

  // a fault arriving with the clear still sets its bit
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_r  <= 5'h00;
      retired_r <= 1'b0;
    end else begin
      status_r <= (do_clear ? 5'h00 : status_r) | {cml_set, fault_s2}; // RULE13
      if (new_evt) retired_r <= 1'b0;
      else if (ara_retire_r) retired_r <= 1'b1; // RULE17
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      alert_oe_r <= 1'b0;
      od_low_r   <= 1'b0;
    end else begin
      alert_oe_r <= alert_act; // RULE10
      od_low_r   <= 1'b0;
    end
  end

  // apb: zero-wait answer, pready in the first access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_en_r <= `PMBSA_RST_CTRL;
      prdata_r  <= 32'h00000000;
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
    end else begin
      pready_r  <= psel & ~penable;
      pslverr_r <= 1'b0;
      prdata_r  <= 32'h00000000;
      if (psel && !penable) begin
        case (paddr)
          `PMBSA_OFF_CTRL: begin
            if (pwrite) ctrl_en_r <= pwdata[0];
            prdata_r <= {31'h00000000, ctrl_en_r};
          end
          `PMBSA_OFF_STATUS:
            prdata_r <= {15'h0000, strap_ok_r, 1'b0, strap_addr_r, alert_act,
                         alert_cfg_w_r[`PMBSA_ARA_MODE_BIT], 2'h0, status_r};
          `PMBSA_OFF_VOUT:      prdata_r <= {16'h0000, vout_w_r};
          `PMBSA_OFF_VOUT_NV:   prdata_r <= {16'h0000, vout_nv_r};
          `PMBSA_OFF_VIN_ON:    prdata_r <= {16'h0000, vin_on_w_r};
          `PMBSA_OFF_VIN_ON_NV: prdata_r <= {16'h0000, vin_on_nv_r};
          `PMBSA_OFF_ALERT_CFG: prdata_r <= {16'h0000, alert_cfg_nv_r, alert_cfg_w_r};
          default:              pslverr_r <= 1'b1;
        endcase
      end
    end
  end

  assign prdata   = prdata_r;
  assign pready   = pready_r;
  assign pslverr  = pslverr_r;
  assign scl_o    = od_low_r;
  assign sda_o    = od_low_r;
  assign scl_oe   = scl_oe_r;
  assign sda_oe   = sda_oe_r;
  assign alert_o  = od_low_r;
  assign alert_oe = alert_oe_r;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_store;
    do_store;
  endsequence
  sequence s_quiet_clear;
    do_clear && fault_s2 == 4'h0 ##1 fault_s2 == 4'h0;
  endsequence

  a_stretch_len: assert property ( // RULE2
    stretch_req_r |=> scl_oe_r [*4] ##1 !scl_oe_r) else $error("stretch length wrong");
  a_pec_reject: assert property ( // RULE3
    exec_r && pec_bad |=> $stable(vout_w_r) && $stable(vin_on_w_r))
    else $error("write taken despite bad check byte");
  a_exp_fixed: assert property ( // RULE6
    vin_on_w_r[15:11] == `PMBSA_VIN_EXP) else $error("exponent altered");
  a_nv_hold: assert property ( // RULE8
    !do_store |=> $stable(vout_nv_r) && $stable(vin_on_nv_r) && $stable(alert_cfg_nv_r))
    else $error("non-volatile copy changed without store");
  a_store_copy: assert property ( // RULE9
    s_store |=> vout_nv_r == vout_w_r && vin_on_nv_r == vin_on_w_r)
    else $error("store did not copy settings");
  a_alert_drive: assert property ( // RULE10
    alert_act |=> alert_oe_r) else $error("alert not driven");
  a_clear_release: assert property ( // RULE13
    s_quiet_clear |=> !alert_oe_r) else $error("clear did not release alert");
  // checks the match decision itself, not the address mux
  a_ara_addr: assert property ( // RULE15
    state_r == ST_ADDR && scl_rise && bitcnt_r == 3'h7 && ara_now &&
    shreg_r[6:0] == {1'b0, strap_addr_r} && {1'b0, strap_addr_r} != `PMBSA_ARA_ADDR
    |=> state_r != ST_ACKA)
    else $error("response mode answered strapped address");
  a_default_strap: assert property ( // RULE12
    !alert_cfg_w_r[`PMBSA_ARA_MODE_BIT] |-> active_addr == {1'b0, strap_addr_r})
    else $error("default mode left strapped address");
  a_resume_strap: assert property ( // RULE17
    ara_retire_r && !new_evt |=> active_addr == {1'b0, strap_addr_r})
    else $error("strapped address not resumed");
  a_strap_hold: assert property ( // RULE22
    strap_ok_r |=> $stable(strap_addr_r) && strap_ok_r) else $error("strap address moved");

endmodule

// ### verif/pmbsa_bus_master.sv
// Purpose: bus master partner for the power-management slave
// Assumes: both wires pulled up; the bench merges the levels
// Notes:   bit time 33 pclk plus any stretch, a 165 ns link clock
`timescale 1ns/10ps
module pmbsa_bus_master (
  input  wire logic pclk,
  input  wire logic scl_line,
  input  wire logic sda_line,
  output logic      scl_m,
  output logic      sda_m
);
  initial begin
    scl_m = 1'b1;
    sda_m = 1'b1;
  end
  task automatic hc();
    repeat (8) @(posedge pclk);
  endtask
  // release waits while the slave stretches the clock
  task automatic rise();
    int n;
    n = 0;
    scl_m <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (scl_line !== 1'b1 && n < 400);
  endtask
  task automatic bitx(input logic b, output logic r);
    sda_m <= b;
    hc();
    rise();
    hc();
    r = sda_line;
    hc();
    scl_m <= 1'b0;
    hc();
  endtask
  task automatic start();
    sda_m <= 1'b1;
    hc();
    rise();
    hc();
    sda_m <= 1'b0;
    hc();
    scl_m <= 1'b0;
    hc();
  endtask
  task automatic stop();
    sda_m <= 1'b0;
    hc();
    rise();
    hc();
    sda_m <= 1'b1;
    hc();
  endtask
  // mack 1 releases data for the slave's acknowledge
  task automatic xbyte(input logic [7:0] d, input logic mack, output logic [7:0] q,
                       output logic ack);
    logic a;
    for (int i = 7; i >= 0; i--) bitx(d[i], q[i]);
    bitx(mack, a);
    ack = ~a;
  endtask
endmodule

// ### verif/pmbsa_slave_tb_top.sv
// Purpose: self-checking bench for the power-management slave
// Assumes: straps 37 and 55 kilohm give bus address 35
// Notes:   stretch limit shortened to 100 pclk
`timescale 1ns/10ps
`include "pmbsa_consts.svh"
module pmbsa_slave_tb_top;
  localparam logic [7:0] AW = 8'h46;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic        scl_oe, sda_oe, alert_oe, scl_m, sda_m, ok, er, scl_o, sda_o, alert_o;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0]  fault_in;
  logic [7:0]  lo_s, hi_s, d, p;
  logic [7:0]  q [$];
  logic [7:0]  tbl [8] = '{8'h0a, 8'h0f, 8'h18, 8'h25, 8'h37, 8'h55, 8'h82, 8'hc8};
  int          error_cnt = 0;
  int          checks_done = 0;
  int          sc_len = 0;
  // open drain: a pin is low only while enabled with a low level
  wire         scl_line = scl_m & ~(scl_oe & ~scl_o);
  wire         sda_line = sda_m & ~(sda_oe & ~sda_o);
  pmbsa_slave #(.STRETCH_MAX_CYC(100)) dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .scl_i(scl_line), .scl_o(scl_o), .scl_oe(scl_oe), .sda_i(sda_line), .sda_o(sda_o),
    .sda_oe(sda_oe), .alert_o(alert_o), .alert_oe(alert_oe), .fault_in(fault_in),
    .address_low_digit_strap(lo_s), .address_high_digit_strap(hi_s));
  pmbsa_bus_master m (.pclk(pclk), .scl_line(scl_line), .sda_line(sda_line),
    .scl_m(scl_m), .sda_m(sda_m));
  task automatic wrap_up();
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  function automatic logic [7:0] crc8(input logic [7:0] b [$]);
    logic [7:0] c = 8'h00;
    foreach (b[i]) begin
      c ^= b[i];
      repeat (8) c = c[7] ? {c[6:0], 1'b0} ^ 8'h07 : {c[6:0], 1'b0};
    end
    return c;
  endfunction
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd,
                     output logic [31:0] r, output logic e);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
    if (n >= 20) chk("apb_wait", 32'h0, 32'h1);
  endtask
  task automatic rreg(input string nm, input logic [11:0] a, input logic [31:0] mk,
                      input logic [31:0] e);
    apb(1'b0, a, 32'h0, rd, er);
    chk(nm, e, rd & mk);
  endtask
  task automatic do_reset();
    presetn <= 1'b0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    repeat (20) @(posedge pclk);
  endtask
  task automatic pm_wr(input logic [7:0] b [$], output logic all);
    logic a;
    all = 1'b1;
    m.start();
    foreach (b[i]) begin
      m.xbyte(b[i], 1'b1, d, a);
      all &= a;
    end
    m.stop();
  endtask
  task automatic pm_rd(input logic [7:0] cmd, output logic all);
    logic a, b, c, x;
    m.start();
    m.xbyte(AW, 1'b1, d, a);
    m.xbyte(cmd, 1'b1, d, b);
    m.start();
    m.xbyte(AW | 8'h01, 1'b1, d, c);
    m.xbyte(8'hff, 1'b0, d, x);
    m.xbyte(8'hff, 1'b1, p, x);
    m.stop();
    all = a & b & c;
  endtask
  task automatic ara_rd(output logic a);
    logic x;
    m.start();
    m.xbyte(8'h19, 1'b1, d, a);
    m.xbyte(8'hff, 1'b0, d, x);
    m.xbyte(8'hff, 1'b1, p, x);
    m.stop();
  endtask
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    sc_len = scl_oe ? sc_len + 1 : 0;
    if (sc_len == 101) chk("stretch_len", 32'h0, 32'h1);
  end
  initial begin
    #400us;
    error_cnt++;
    wrap_up();
  end
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata, fault_in, lo_s, hi_s} = '0;
    for (int i = 0; i < 8; i++) begin
      lo_s <= tbl[i];
      hi_s <= tbl[7-i];
      do_reset();
      rreg("strap", `PMBSA_OFF_STATUS, 32'h17e00, {16'h1, 1'b0, 3'(7-i), 3'(i), 9'h0});
    end
    lo_s <= tbl[3];
    hi_s <= tbl[4];
    do_reset();
    lo_s <= tbl[0];
    repeat (10) @(posedge pclk);
    rreg("strap_hold", `PMBSA_OFF_STATUS, 32'h7e00, 32'h4600);
    rreg("ctrl", `PMBSA_OFF_CTRL, 32'h1, 32'h1);
    rreg("cfg", `PMBSA_OFF_ALERT_CFG, 32'hffff, 32'h0);
    apb(1'b1, 12'h01c, 32'h0, rd, er);
    chk("unmapped", 32'h1, 32'(er));
    apb(1'b1, `PMBSA_OFF_CTRL, 32'h0, rd, er);
    pm_wr('{AW, 8'h03}, ok);
    chk("ctrl_off", 32'h0, 32'(ok));
    apb(1'b1, `PMBSA_OFF_CTRL, 32'h1, rd, er);
    rreg("ctrl_on", `PMBSA_OFF_CTRL, 32'h1, 32'h1);
    pm_wr('{AW, 8'h21, 8'h34, 8'h12}, ok);
    chk("wr_ack", 32'h1, 32'(ok));
    rreg("vout", `PMBSA_OFF_VOUT, 32'hffff, 32'h1234);
    rreg("vout_nv", `PMBSA_OFF_VOUT_NV, 32'hffff, 32'hc000);
    q = '{AW, 8'h35, 8'hff, 8'hff};
    q.push_back(crc8(q));
    pm_wr(q, ok);
    rreg("vin_exp", `PMBSA_OFF_VIN_ON, 32'hffff, 32'hebff);
    q = '{AW, 8'h21, 8'h00, 8'h00};
    q.push_back(~crc8(q));
    pm_wr(q, ok);
    rreg("pec_bad", `PMBSA_OFF_VOUT, 32'hffff, 32'h1234);
    pm_wr('{AW, 8'h11}, ok);
    rreg("vout_st", `PMBSA_OFF_VOUT_NV, 32'hffff, 32'h1234);
    rreg("vin_st", `PMBSA_OFF_VIN_ON_NV, 32'hffff, 32'hebff);
    pm_wr('{AW, 8'h20, 8'h15}, ok);
    pm_rd(8'h20, ok);
    chk("mode", 32'h14, 32'(d));
    pm_rd(8'h21, ok);
    chk("vout_lo", 32'h34, 32'(d));
    chk("vout_hi", 32'h12, 32'(p));
    pm_rd(8'h78, ok);
    chk("stat", 32'h10, 32'(d));
    chk("pec_out", 32'(crc8('{AW, 8'h78, 8'h47, 8'h10})), 32'(p));
    pm_wr('{AW, 8'h03}, ok);
    fault_in <= 4'h1;
    repeat (8) @(posedge pclk);
    chk("alert_on", 32'h1, 32'(alert_oe & ~alert_o));
    ara_rd(ok);
    chk("ara_off", 32'h0, 32'(ok));
    pm_rd(8'h78, ok);
    chk("strap_alert", 32'h1, 32'(ok));
    chk("stat_fault", 32'h1, 32'(d));
    fault_in <= 4'h0;
    pm_wr('{AW, 8'h03}, ok);
    chk("alert_clr", 32'h0, 32'(alert_oe));
    pm_wr('{AW, 8'hd5, 8'h10}, ok);
    rreg("ara_mode", `PMBSA_OFF_STATUS, 32'h80, 32'h80);
    fault_in <= 4'h2;
    repeat (8) @(posedge pclk);
    fault_in <= 4'h0;
    pm_rd(8'h78, ok);
    chk("strap_drop", 32'h0, 32'(ok));
    ara_rd(ok);
    chk("ara_addr", 32'h46, 32'(d));
    chk("ara_pec", 32'(crc8('{8'h19, 8'h46})), 32'(p));
    chk("alert_ret", 32'h0, 32'(alert_oe));
    pm_rd(8'h78, ok);
    chk("strap_back", 32'h1, 32'(ok));
    wrap_up();
  end
endmodule
